// ---- verilog/usir_core.sv ----
// Serial core with infrared encoder and decoder, DMA requests and RTS/CTS flow control.
//
// Behaviour
// - Normal infrared mode sends a zero as a 3/16 bit high pulse.
// - Infrared path needs to support bit rates up to 115.2 Kbps only.
// - Infrared encoder output rests low when idle.
// - Decoder idles high, low pulses become zeros, a low input starts a frame.
// - Decoder ignores input while sending; encoder stays quiet while receiving.
// - Glitch filter rejects pulses under one prescaler period, accepts above two.
// - A zero prescaler value stops the infrared encoder and decoder.
// - Low-power infrared pulse lasts three periods of the prescaled clock.
// - Receive and transmit DMA requests are generated independently.
// - Transmit DMA requests a data write whenever transmit-empty is set.
// - Receive DMA requests a data read whenever receive-not-empty is set.
// - Multi-buffer errors flag after the byte completes, then interrupt if enabled.
// - Framing and noise flags rise with receive-not-empty, overrun when a byte arrives while it is set; each enabled.
// - RTS and CTS flow control have separate enables and act independently.
// - With RTS enabled, RTS is low while the receiver can take data.
// - RTS rises at every stop start, whether or not data is waiting, and falls when a data read clears it.
// - With CTS enabled, frames start only while CTS is low and data waits.
// - With CTS enabled, each CTS toggle sets the change flag and may interrupt.
// - Transmit-empty sets on move to the shifter and clears on data write.
// - A data register read clears receive-not-empty.
`timescale 1ns/10ps
`include "usir_cfg.svh"

module usir_core (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rstn,
   // Register port.
   input wire usir_pkg::usir_addr_t reg_addr,
   input wire usir_pkg::usir_word_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output usir_pkg::usir_word_t reg_rdata,
   // Serial and flow-control pins.
   input wire logic ser_rx,
   output logic ser_tx,
   input wire logic cts_n,
   output logic rts_n,
   // DMA requests and interrupt.
   output logic dma_tx_req,
   output logic dma_rx_req,
   output logic irq
);
   import usir_pkg::*;

   // ==========================================================
   // Registers and state.
   logic [`USIR_CTRL_BITS-1:0] ctrl_q;
   logic [15:0] baud_q, baud_cnt_q;
   logic [7:0] presc_q, lp_cnt_q;
   logic rx_s1_q, rx_s2_q, cts_s1_q, cts_s2_q, cts_prev_q;
   usir_state_t tx_state_q, rx_state_q;
   logic [3:0] tx_sub_q, rx_sub_q, stretch_q;
   logic [2:0] tx_bit_q, rx_bit_q, smp_q;
   logic [7:0] tx_shift_q, tx_buf_q, rx_shift_q, rdr_q;
   logic [1:0] lp_pulse_q, lowcnt_q;
   logic tx_full_q, tx_complete_flag_q, rx_not_empty_flag_q, fe_q, ore_q, ne_q, clear_to_send_change_flag_q, noise_q;
   logic rts_hold_q, rx_dec_q;
   logic ser_tx_q, rts_n_q, dma_tx_req_q, dma_rx_req_q, irq_q;
   usir_word_t rdata_q;

   // Majority vote of three samples.
   function automatic logic maj3(input logic [2:0] s);
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction : maj3

   // Register access decode.
   function automatic logic hit(input usir_addr_t a, input usir_addr_t off);
      hit = (a == off);
   endfunction : hit

   // ==========================================================
   // Decode and control wires.
   wire wr_stat = reg_wr & hit(reg_addr, `USIR_OFF_STAT);
   wire wr_data = reg_wr & hit(reg_addr, `USIR_OFF_DATA);
   wire rd_data = reg_rd & hit(reg_addr, `USIR_OFF_DATA);
   wire ue = ctrl_q[`USIR_C_UE];
   wire irda = ctrl_q[`USIR_C_IRDA];
   wire lowpow = ctrl_q[`USIR_C_LP];
   wire rts_en = ctrl_q[`USIR_C_RTS];
   wire cts_en = ctrl_q[`USIR_C_CTS];
   wire div_ok = (presc_q != 8'h00);
   wire tick = (baud_cnt_q == `USIR_ZERO16) & (baud_q != `USIR_ZERO16);
   wire lp_tick = (lp_cnt_q == 8'h00) & div_ok;
   wire tx_busy = (tx_state_q != USIR_IDLE);
   wire rx_busy = (rx_state_q != USIR_IDLE);
   wire sub_end_tx = tick & (tx_sub_q == `USIR_SUB_LAST);
   wire sub_smp_rx = tick & (rx_sub_q == `USIR_SUB_SAMPLE);
   wire sub_end_rx = tick & (rx_sub_q == `USIR_SUB_LAST);
   wire vote = maj3(smp_q);
   wire disagree = ~(&smp_q) & (|smp_q);

   // ==========================================================
   // Transmit control: frames start only when allowed by CTS and half-duplex.
   wire cts_ok = ~cts_en | ~cts_s2_q;
   wire tx_go = ~tx_busy & tx_full_q & tick & ue & cts_ok & ~(irda & rx_busy);
   wire tx_last = (tx_bit_q == `USIR_LAST_BIT);
   wire tx_done = sub_end_tx & (tx_state_q == USIR_STOP);
   wire nrz = (tx_state_q == USIR_START) ? 1'b0 :
              (tx_state_q == USIR_DATA) ? tx_shift_q[0] : 1'b1;
   wire next_zero = ((tx_state_q == USIR_START) & ~tx_shift_q[0]) |
                    ((tx_state_q == USIR_DATA) & ~tx_last & ~tx_shift_q[1]);
   wire lp_load = tx_go | (sub_end_tx & next_zero);
   wire norm_pulse = ~nrz & tx_busy & (tx_sub_q < `USIR_IR_PULSE_TICKS);
   wire lp_pulse = (lp_pulse_q != 2'h0);
   wire ir_out = div_ok & ~rx_busy & (lowpow ? lp_pulse : norm_pulse);
   wire ser_tx_d = irda ? ir_out : nrz;

   // Transmit frame sequencer on oversampling ticks.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_state_q <= USIR_IDLE;
         tx_sub_q <= 4'h0;
         tx_bit_q <= 3'h0;
         tx_shift_q <= 8'h00;
      end else if (tx_go) begin
         tx_state_q <= USIR_START;
         tx_sub_q <= 4'h0;
         tx_shift_q <= tx_buf_q;
      end else if (tick & tx_busy) begin
         tx_sub_q <= tx_sub_q + 4'h1;
         if (sub_end_tx) begin
            case (tx_state_q)
               USIR_START: begin
                  tx_state_q <= USIR_DATA;
                  tx_bit_q <= 3'h0;
               end
               USIR_DATA: begin
                  tx_shift_q <= {1'b1, tx_shift_q[7:1]};
                  tx_bit_q <= tx_bit_q + 3'h1;
                  if (tx_last) begin
                     tx_state_q <= USIR_STOP;
                  end
               end
               default: tx_state_q <= USIR_IDLE;
            endcase
         end
      end
   end

   // Transmit buffer: empty flag sets on move to shifter, clears on data write.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_full_q <= 1'b0;
         tx_buf_q <= 8'h00;
      end else begin
         tx_full_q <= wr_data | (tx_full_q & ~tx_go);
         if (wr_data) begin
            tx_buf_q <= reg_wdata[7:0];
         end
      end
   end

   // ==========================================================
   // Baud tick and low-power clock prescalers.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         baud_cnt_q <= `USIR_ZERO16;
         lp_cnt_q <= 8'h00;
         lp_pulse_q <= 2'h0;
      end else begin
         baud_cnt_q <= tick ? baud_q - 16'h0001 : baud_cnt_q - {15'h0000, |baud_cnt_q};
         lp_cnt_q <= lp_tick ? presc_q - 8'h01 : lp_cnt_q - {7'h00, |lp_cnt_q};
         lp_pulse_q <= lp_load ? `USIR_LP_PULSE_PERIODS :
                       lp_pulse_q - {1'b0, lp_tick & lp_pulse};
      end
   end

   // ==========================================================
   // Input synchronisers and infrared decoder with glitch filter.
   wire ir_quiet = tx_busy | ~div_ok;
   wire ir_low = ~rx_s2_q & ~ir_quiet;
   wire ir_accept = ir_low & lp_tick & (lowcnt_q == `USIR_GLITCH_PERIODS - 2'h1);
   wire ir_dec = (stretch_q == 4'h0) & ~ir_accept;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rx_s1_q <= 1'b1;
         rx_s2_q <= 1'b1;
         cts_s1_q <= 1'b1;
         cts_s2_q <= 1'b1;
         cts_prev_q <= 1'b1;
         lowcnt_q <= 2'h0;
         stretch_q <= 4'h0;
         rx_dec_q <= 1'b1;
      end else begin
         rx_s1_q <= ser_rx;
         rx_s2_q <= rx_s1_q;
         cts_s1_q <= cts_n;
         cts_s2_q <= cts_s1_q;
         cts_prev_q <= cts_s2_q;
         lowcnt_q <= ~ir_low ? 2'h0 :
                     (lp_tick & (lowcnt_q != `USIR_GLITCH_PERIODS)) ? lowcnt_q + 2'h1 : lowcnt_q;
         stretch_q <= ir_accept ? `USIR_STRETCH_TICKS :
                      stretch_q - {3'h0, tick & (stretch_q != 4'h0)};
         rx_dec_q <= irda ? (ir_dec | ir_quiet) : rx_s2_q;
      end
   end

   // ==========================================================
   // Receive frame sequencer with three-sample majority vote.
   wire rx_begin = ~rx_busy & ue & ~rx_dec_q;
   wire stop_start = sub_end_rx & (rx_state_q == USIR_DATA) & (rx_bit_q == `USIR_LAST_BIT);
   wire rx_deliver = sub_smp_rx & (rx_state_q == USIR_STOP);
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rx_state_q <= USIR_IDLE;
         rx_sub_q <= 4'h0;
         rx_bit_q <= 3'h0;
         rx_shift_q <= 8'h00;
         smp_q <= 3'h7;
         noise_q <= 1'b0;
      end else begin
         if (tick) begin
            smp_q <= {smp_q[1:0], rx_dec_q};
         end
         if (rx_begin) begin
            rx_state_q <= USIR_START;
            rx_sub_q <= 4'h0;
            noise_q <= 1'b0;
         end else if (tick & rx_busy) begin
            rx_sub_q <= rx_sub_q + 4'h1;
            if (sub_smp_rx) begin
               noise_q <= noise_q | disagree;
            end
            case (rx_state_q)
               USIR_START: begin
                  if (sub_smp_rx & vote) begin
                     rx_state_q <= USIR_IDLE;
                  end else if (sub_end_rx) begin
                     rx_state_q <= USIR_DATA;
                     rx_bit_q <= 3'h0;
                  end
               end
               USIR_DATA: begin
                  if (sub_smp_rx) begin
                     rx_shift_q <= {vote, rx_shift_q[7:1]};
                  end
                  if (sub_end_rx) begin
                     rx_bit_q <= rx_bit_q + 3'h1;
                     if (stop_start) begin
                        rx_state_q <= USIR_STOP;
                     end
                  end
               end
               USIR_STOP: begin
                  if (sub_smp_rx) begin
                     rx_state_q <= USIR_IDLE;
                  end
               end
               default: rx_state_q <= USIR_IDLE;
            endcase
         end
      end
   end

   // ==========================================================
   // Status flags: hardware set wins over a write-zero or read clear.
   wire rx_not_empty_flag_d = (rx_deliver & ~rx_not_empty_flag_q) |
                 (rx_not_empty_flag_q & ~rd_data & ~(wr_stat & ~reg_wdata[`USIR_S_RX_NOT_EMPTY_FLAG]));
   wire clear_to_send_change_flag_set = cts_en & (cts_s2_q != cts_prev_q);
   wire flag_ok = rx_deliver & ~rx_not_empty_flag_q;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rx_not_empty_flag_q <= 1'b0;
         rdr_q <= 8'h00;
         fe_q <= 1'b0;
         ne_q <= 1'b0;
         ore_q <= 1'b0;
         tx_complete_flag_q <= 1'b1;
         clear_to_send_change_flag_q <= 1'b0;
         rts_hold_q <= 1'b0;
      end else begin
         rx_not_empty_flag_q <= rx_not_empty_flag_d;
         if (flag_ok) begin
            rdr_q <= rx_shift_q;
         end
         // Framing and noise errors appear only when the byte completes, together with RX_NOT_EMPTY_FLAG.
         fe_q <= (flag_ok & ~vote) | (fe_q & ~(wr_stat & ~reg_wdata[`USIR_S_FE]));
         ne_q <= (flag_ok & (noise_q | disagree)) |
                 (ne_q & ~(wr_stat & ~reg_wdata[`USIR_S_NE]));
         ore_q <= (rx_deliver & rx_not_empty_flag_q) | (ore_q & ~(wr_stat & ~reg_wdata[`USIR_S_ORE]));
         tx_complete_flag_q <= (tx_done & ~tx_full_q) |
                   (tx_complete_flag_q & ~wr_data & ~(wr_stat & ~reg_wdata[`USIR_S_TX_COMPLETE_FLAG]));
         clear_to_send_change_flag_q <= clear_to_send_change_flag_set | (clear_to_send_change_flag_q & ~(wr_stat & ~reg_wdata[`USIR_S_CLEAR_TO_SEND_CHANGE_FLAG]));
         rts_hold_q <= stop_start | (rts_hold_q & ~rd_data);
      end
   end

   // ==========================================================
   // Software registers and read data, one cycle after the strobe.
   wire [15:0] stat_w = {6'h00, clear_to_send_change_flag_q, 1'b0, ~tx_full_q, tx_complete_flag_q, rx_not_empty_flag_q, 2'h0,
                         ore_q, fe_q, ne_q};
   wire [15:0] rd_mux = hit(reg_addr, `USIR_OFF_STAT) ? stat_w :
                        hit(reg_addr, `USIR_OFF_DATA) ? {8'h00, rdr_q} :
                        hit(reg_addr, `USIR_OFF_BAUD) ? baud_q :
                        hit(reg_addr, `USIR_OFF_CTRL) ? {1'b0, ctrl_q} :
                        hit(reg_addr, `USIR_OFF_PRESC) ? {8'h00, presc_q} : `USIR_ZERO16;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= `USIR_CTRL_RST;
         baud_q <= `USIR_BAUD_RST;
         presc_q <= `USIR_PRESC_RST;
         rdata_q <= `USIR_ZERO16;
      end else begin
         if (reg_wr & hit(reg_addr, `USIR_OFF_CTRL)) begin
            ctrl_q <= reg_wdata[`USIR_CTRL_BITS-1:0];
         end
         if (reg_wr & hit(reg_addr, `USIR_OFF_BAUD)) begin
            baud_q <= reg_wdata;
         end
         if (reg_wr & hit(reg_addr, `USIR_OFF_PRESC)) begin
            presc_q <= reg_wdata[7:0];
         end
         rdata_q <= reg_rd ? rd_mux : `USIR_ZERO16;
      end
   end

   // ==========================================================
   // Pin, request and interrupt outputs, all registered.
   wire irq_d = (clear_to_send_change_flag_q & ctrl_q[`USIR_C_CTSIE]) | (~tx_full_q & ctrl_q[`USIR_C_TDEIE]) |
                (tx_complete_flag_q & ctrl_q[`USIR_C_TRACIE]) |
                ((rx_not_empty_flag_q | ore_q) & ctrl_q[`USIR_C_RDNEIE]) |
                (ctrl_q[`USIR_C_RXDMA] & ctrl_q[`USIR_C_ERRIE] & (fe_q | ne_q | ore_q)) |
                (fe_q & ctrl_q[`USIR_C_FEIE]) | (ore_q & ctrl_q[`USIR_C_OREIE]) |
                (ne_q & ctrl_q[`USIR_C_NEIE]);
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ser_tx_q <= 1'b1;
         rts_n_q <= 1'b0;
         dma_tx_req_q <= 1'b0;
         dma_rx_req_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         ser_tx_q <= ser_tx_d;
         rts_n_q <= rts_en & (stop_start | (rts_hold_q & ~rd_data));
         dma_tx_req_q <= ctrl_q[`USIR_C_TXDMA] & ~(wr_data | (tx_full_q & ~tx_go));
         dma_rx_req_q <= ctrl_q[`USIR_C_RXDMA] & rx_not_empty_flag_d;
         irq_q <= irq_d;
      end
   end

   assign ser_tx = ser_tx_q;
   assign rts_n = rts_n_q;
   assign dma_tx_req = dma_tx_req_q;
   assign dma_rx_req = dma_rx_req_q;
   assign irq = irq_q;
   assign reg_rdata = rdata_q;

   // ==========================================================
   // Checks on the block's own behaviour.
   sequence s_data_read;
      rd_data && rx_not_empty_flag_q && !rx_busy && !stop_start;
   endsequence
   sequence s_released;
      !rx_not_empty_flag_q && !rts_n_q;
   endsequence

   a_ir_idle_low: assert property (@(posedge core_clk) disable iff (!rstn)
      (irda && !tx_busy) [*2] |=> !ser_tx_q) else $error("infrared output not low at idle");
   a_norm_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
      (ser_tx_q && $past(irda) && !$past(lowpow)) |-> $past(tx_sub_q) < `USIR_IR_PULSE_TICKS)
      else $error("normal infrared pulse longer than three ticks");
   a_div_zero: assert property (@(posedge core_clk) disable iff (!rstn)
      (irda && presc_q == 8'h00) |=> !ser_tx_q && rx_dec_q)
      else $error("infrared path active with zero prescaler");
   a_tx_dma_req: assert property (@(posedge core_clk) disable iff (!rstn)
      dma_tx_req_q |-> !tx_full_q) else $error("transmit request while buffer full");
   a_rx_dma_req: assert property (@(posedge core_clk) disable iff (!rstn)
      (ctrl_q[`USIR_C_RXDMA] && $rose(rx_not_empty_flag_q)) |-> dma_rx_req_q)
      else $error("receive request missing with data ready");
   a_rts_release: assert property (@(posedge core_clk) disable iff (!rstn)
      s_data_read |=> s_released) else $error("data read did not release RTS");
   a_cts_flag: assert property (@(posedge core_clk) disable iff (!rstn)
      (cts_en && cts_s2_q != cts_prev_q) |=> clear_to_send_change_flag_q) else $error("CTS toggle not flagged");
   a_cts_block: assert property (@(posedge core_clk) disable iff (!rstn)
      (cts_en && !tx_busy ##1 tx_busy) |-> !$past(cts_s2_q))
      else $error("frame started while CTS high");
   a_half_duplex: assert property (@(posedge core_clk) disable iff (!rstn)
      (irda && tx_busy) |=> rx_dec_q) else $error("decoder not quiet during transmit");
   a_err_with_rx_not_empty_flag: assert property (@(posedge core_clk) disable iff (!rstn)
      ($rose(fe_q) || $rose(ne_q)) |-> $rose(rx_not_empty_flag_q))
      else $error("error flag raised apart from receive-not-empty");

endmodule : usir_core

// ---- shared/usir_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the infrared serial block.
`ifndef USIR_CFG_SVH
`define USIR_CFG_SVH

// =============================================================
// Register offsets (byte addresses on the plain register port)
`define USIR_OFF_STAT 5'h00
`define USIR_OFF_DATA 5'h04
`define USIR_OFF_BAUD 5'h08
`define USIR_OFF_CTRL 5'h0c
`define USIR_OFF_PRESC 5'h10

// =============================================================
// Control register fields
`define USIR_C_UE 0
`define USIR_C_IRDA 1
`define USIR_C_LP 2
`define USIR_C_TXDMA 3
`define USIR_C_RXDMA 4
`define USIR_C_RTS 5
`define USIR_C_CTS 6
`define USIR_C_CTSIE 7
`define USIR_C_TDEIE 8
`define USIR_C_TRACIE 9
`define USIR_C_RDNEIE 10
`define USIR_C_ERRIE 11
`define USIR_C_FEIE 12
`define USIR_C_OREIE 13
`define USIR_C_NEIE 14
`define USIR_CTRL_BITS 15

// =============================================================
// Status register fields
`define USIR_S_NE 0
`define USIR_S_FE 1
`define USIR_S_ORE 2
`define USIR_S_RX_NOT_EMPTY_FLAG 5
`define USIR_S_TX_COMPLETE_FLAG 6
`define USIR_S_TDE 7
`define USIR_S_CLEAR_TO_SEND_CHANGE_FLAG 9

// =============================================================
// Reset values
`define USIR_CTRL_RST 15'h0000
`define USIR_BAUD_RST 16'h0008
`define USIR_PRESC_RST 8'h01
`define USIR_ZERO16 16'h0000

// =============================================================
// Timing counts, in oversampling ticks or low-power clock periods
`define USIR_SUB_LAST 4'hf
`define USIR_SUB_SAMPLE 4'h9
`define USIR_IR_PULSE_TICKS 4'h3
`define USIR_LP_PULSE_PERIODS 2'h3
`define USIR_GLITCH_PERIODS 2'h2
`define USIR_STRETCH_TICKS 4'he
`define USIR_LAST_BIT 3'h7

`endif

// ---- shared/usir_pkg.sv ----
// Types shared by the infrared serial block.
package usir_pkg;

   // ==========================================================
   // Bus words and state encodings.
   typedef logic [15:0] usir_word_t;
   typedef logic [4:0] usir_addr_t;

   // Gray order along the frame: idle, start, data, stop.
   typedef enum logic [1:0] {
      USIR_IDLE = 2'h0,
      USIR_START = 2'h1,
      USIR_DATA = 2'h3,
      USIR_STOP = 2'h2
   } usir_state_t;

endpackage : usir_pkg

// ---- tb/usir_peer.sv ----
// Infrared transceiver model that drives the receive pin of the core.
`timescale 1ns/10ps

module usir_peer (
   // Clock.
   input wire logic core_clk,
   // Frame request from the bench.
   input wire logic go,
   input wire logic [7:0] data,
   input wire logic [7:0] plen,
   input wire logic [7:0] bitc,
   // Receive pin and status.
   output logic ser_rx,
   output logic busy
);
   logic [9:0] frame;
   int i;
   int c;

   // ==========================================================
   // Frame sender
   // Each zero bit is a low pulse of plen cycles at the cell start; the line idles high.
   initial begin
      ser_rx = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge core_clk);
         if (go === 1'b1) begin
            busy <= 1'b1;
            frame = {1'b1, data, 1'b0};
            for (i = 0; i < 10; i++) begin
               for (c = 0; c < bitc; c++) begin
                  ser_rx <= !(frame[i] == 1'b0 && c < plen);
                  @(posedge core_clk);
               end
            end
            // A quiet gap keeps the half-duplex turnaround, scaled down.
            repeat (bitc) @(posedge core_clk);
            busy <= 1'b0;
         end
      end
   end
endmodule : usir_peer

// ---- tb/usir_core_bench.sv ----
// Self-checking bench for the infrared serial core.
`timescale 1ns/10ps
`include "usir_cfg.svh"

module usir_core_bench;
   import usir_pkg::*;
   // ==========================================================
   // Stimulus, observation and bookkeeping
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   usir_addr_t reg_addr = '0;
   usir_word_t reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic cts_n = 1'b0;
   usir_word_t reg_rdata;
   logic ser_rx, ser_tx, rts_n, dma_tx_req, dma_rx_req, irq;
   logic go = 1'b0;
   logic [7:0] p_data = 8'h00;
   logic [7:0] p_len = 8'h06;
   logic busy;
   logic rd_d = 1'b0;
   int n_fail = 0;
   int checks_done = 0;
   int cyc = 0;
   int seed = 32'hd99a;
   int h;
   logic [7:0] b;
   usir_word_t exp_q[$];
   usir_word_t msk_q[$];

   // The clock toggles every 2 ns, half of its 4 ns period.
   initial forever #2 core_clk = ~core_clk;

   usir_core uut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ser_rx(ser_rx), .ser_tx(ser_tx), .cts_n(cts_n), .rts_n(rts_n),
      .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req), .irq(irq));

   usir_peer peer (.core_clk(core_clk), .go(go), .data(p_data), .plen(p_len),
      .bitc(8'h20), .ser_rx(ser_rx), .busy(busy));

   // Compares a seen value with an expected one and counts both outcomes.
   task chk(input string nm, input usir_word_t s, input usir_word_t e);
      checks_done++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // Single-bit form of the comparison.
   task chk1(input string nm, input logic s, input logic e);
      chk(nm, {15'h0000, s}, {15'h0000, e});
   endtask : chk1

   // One-cycle write strobe.
   task wr(input usir_addr_t a, input usir_word_t d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // One-cycle read strobe; the expected masked word is queued for the monitor.
   task rd(input usir_addr_t a, input usir_word_t e, input usir_word_t m);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask : rd

   task tick(input int k);
      repeat (k) @(posedge core_clk);
   endtask : tick

   // Counts cycles with the transmit pin high.
   task hi_count(input int k);
      h = 0;
      repeat (k) begin
         @(posedge core_clk);
         if (ser_tx === 1'b1) h++;
      end
   endtask : hi_count

   // Asks the far side for one infrared frame and waits until it is quiet.
   task send(input logic [7:0] d, input logic [7:0] l);
      @(posedge core_clk);
      p_data <= d;
      p_len <= l;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      @(negedge busy);
   endtask : send

   task finish_test();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test

   // Read data stand one cycle after the strobe; the oldest note is taken then.
   always @(posedge core_clk) begin
      rd_d <= reg_rd;
      cyc <= cyc + 1;
      if (rd_d === 1'b1 && exp_q.size() > 0) begin
         chk("reg_rdata", reg_rdata & msk_q.pop_front(), exp_q.pop_front());
      end
      if (cyc == 60000) begin
         n_fail++;
         finish_test();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      tick(12);
      rstn <= 1'b1;
      tick(2);
      chk1("rts_n reset", rts_n, 1'b0);
      rd(`USIR_OFF_STAT, 16'h00c0, 16'hffff);
      rd(`USIR_OFF_BAUD, 16'h0008, 16'hffff);
      rd(`USIR_OFF_PRESC, 16'h0001, 16'hffff);
      rd(`USIR_OFF_CTRL, 16'h0000, 16'hffff);
      rd(5'h14, 16'h0000, 16'hffff);
      $display("test reset done");
      wr(`USIR_OFF_CTRL, 16'h0019);
      tick(3);
      chk1("dma_tx_req", dma_tx_req, 1'b1);
      chk1("dma_rx_req idle", dma_rx_req, 1'b0);
      $display("test dma done");
      wr(`USIR_OFF_BAUD, 16'h0002);
      wr(`USIR_OFF_PRESC, 16'h0002);
      wr(`USIR_OFF_CTRL, 16'h0003);
      tick(3);
      chk1("ir idle", ser_tx, 1'b0);
      b = 8'($random(seed));
      wr(`USIR_OFF_DATA, {8'h00, b});
      hi_count(400);
      chk("ir high", h[15:0], 16'(6 * (9 - $countones(b))));
      wr(`USIR_OFF_PRESC, 16'h0004);
      wr(`USIR_OFF_CTRL, 16'h0007);
      wr(`USIR_OFF_DATA, 16'h00ff);
      hi_count(400);
      chk1("lp pulse", h >= 9 && h <= 12, 1'b1);
      $display("test encoder done");
      wr(`USIR_OFF_PRESC, 16'h0002);
      wr(`USIR_OFF_CTRL, 16'h0033);
      b = 8'($random(seed));
      send(b, 8'h06);
      tick(4);
      chk1("rts_n full", rts_n, 1'b1);
      chk1("dma_rx_req", dma_rx_req, 1'b1);
      rd(`USIR_OFF_DATA, {8'h00, b}, 16'hffff);
      tick(2);
      chk1("rts_n freed", rts_n, 1'b0);
      chk1("dma_rx_req read", dma_rx_req, 1'b0);
      send(8'h00, 8'h01);
      rd(`USIR_OFF_STAT, 16'h0000, 16'h0020);
      wr(`USIR_OFF_PRESC, 16'h0000);
      send(8'h55, 8'h06);
      rd(`USIR_OFF_STAT, 16'h0000, 16'h0020);
      $display("test decoder done");
      // Plain line: a zero cell low for 17 of 32 cycles splits the three votes.
      wr(`USIR_OFF_CTRL, 16'h0811);
      send(8'h00, 8'h11);
      chk1("irq err", irq, 1'b1);
      rd(`USIR_OFF_STAT, 16'h0021, 16'h0027);
      // A second byte while the first is unread is dropped and flags overrun.
      send(8'h3c, 8'h20);
      rd(`USIR_OFF_STAT, 16'h0025, 16'h0027);
      rd(`USIR_OFF_DATA, 16'h0000, 16'hffff);
      $display("test errors done");
      wr(`USIR_OFF_CTRL, 16'h00c1);
      wr(`USIR_OFF_STAT, 16'h0000);
      cts_n <= 1'b1;
      tick(6);
      chk1("irq cts", irq, 1'b1);
      chk1("rts_n alone", rts_n, 1'b0);
      rd(`USIR_OFF_STAT, 16'h0200, 16'h0200);
      wr(`USIR_OFF_DATA, 16'h00a5);
      tick(100);
      chk1("tx held", ser_tx, 1'b1);
      rd(`USIR_OFF_STAT, 16'h0000, 16'h0080);
      cts_n <= 1'b0;
      tick(20);
      rd(`USIR_OFF_STAT, 16'h0080, 16'h0080);
      tick(400);
      rd(`USIR_OFF_STAT, 16'h00c0, 16'h00c0);
      $display("test flow control done");
      finish_test();
   end
endmodule : usir_core_bench
